// ==== rtl/sbol_ctrl.sv ====
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module sbol_ctrl
import sbol_pkg::*;
#(
    parameter int COL_W = sbol_pkg::COL_W_DEF,
    parameter int DQ_W = sbol_pkg::DQ_W_DEF,
    parameter int MIN_LAT = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    sbol_if.ctl link
);
    import sbol_pkg::*;

    if (DQ_W != 8 || COL_W < 3 || COL_W > 10 || MIN_LAT < 2 || MIN_LAT > 3) begin : g_chk
        $error("sbol_ctrl: needs DQ_W 8, COL_W 3..10, MIN_LAT 2..3");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Functions
    // Never load reserved latency, test mode or reserved bits
    function automatic logic [MODE_W-1:0] clean_mode(input logic [MODE_W-1:0] m);
        logic [MODE_W-1:0] r;
        logic [2:0] lat;
        r = m;
        lat = m[LAT_MSB:LAT_LSB];
        if (!(lat == LAT_2 || lat == LAT_3) || (lat == LAT_2 && MIN_LAT == 3)) begin
            lat = LAT_3;
        end
        r[LAT_MSB:LAT_LSB] = lat;
        r[OPM_MSB:OPM_LSB] = OPM_NORMAL;
        r[RSV_MSB:RSV_LSB] = 2'b00;
        if (m[BL_MSB:BL_LSB] == BL_FULL) begin
            r[BT_BIT] = 1'b0;
        end
        return r;
    endfunction

    function automatic logic [3:0] beats(input logic [MODE_W-1:0] m, input logic wr);
        logic [3:0] b;
        b = 4'h1;
        if (!(wr && m[WBM_BIT])) begin
            unique case (m[BL_MSB:BL_LSB])
                BL_2: b = 4'h2;
                BL_4: b = 4'h4;
                BL_8: b = 4'h8;
                BL_FULL: b = FULL_PAGE_BEATS;
                default: b = 4'h1;
            endcase
        end
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register bus
    sbol_ctl_state_t state_q;
    logic [MODE_W-1:0] mode_q;
    logic [MODE_W-1:0] cur_q;
    logic [COL_W-1:0] col_q;
    logic [31:0] wd_q [2];
    logic [31:0] rd_q [2];
    logic [31:0] prdata_q;
    logic [3:0] cmd_q;
    logic [11:0] addr_q;
    logic [7:0] dqo_q;
    logic dqoe_q;
    logic wrop_q;
    logic [3:0] cyc_q;
    logic [3:0] rcnt_q;
    logic [3:0] nb_q;
    logic [3:0] gap_q;

    wire setup = psel && !penable;
    wire apb_wr = psel && penable && pwrite;
    wire sel_ctrl = paddr == REG_CTRL;
    wire sel_mode = paddr == REG_MODE;
    wire sel_col = paddr == REG_COL;
    wire sel_wd0 = paddr == REG_WDAT0;
    wire sel_wd1 = paddr == REG_WDAT1;
    wire sel_rd0 = paddr == REG_RDAT0;
    wire sel_rd1 = paddr == REG_RDAT1;
    wire sel_stat = paddr == REG_STAT;
    wire mapped = sel_ctrl | sel_mode | sel_col | sel_wd0 | sel_wd1 | sel_rd0 | sel_rd1
        | sel_stat;
    wire idle = state_q == ST_IDLE;
    wire bad_go = sel_ctrl && pwrite && (!idle || pwdata[1:0] == 2'h3);
    // Orders only taken while idle, so loads see idle banks
    wire go = apb_wr && sel_ctrl && idle && pwdata[1:0] != 2'h3;
    wire [MODE_W-1:0] new_mode = clean_mode(mode_q);
    wire [31:0] stat = {4'h0, cur_q, 4'h0, rcnt_q, 7'h00, !idle};
    wire [31:0] rmux = sel_ctrl ? 32'h00000000 :
        sel_mode ? {20'h00000, mode_q} :
        sel_col ? {{(32 - COL_W){1'b0}}, col_q} :
        sel_wd0 ? wd_q[0] : sel_wd1 ? wd_q[1] :
        sel_rd0 ? rd_q[0] : sel_rd1 ? rd_q[1] : sel_stat ? stat : 32'h00000000;
    wire [3:0] cyc_nx = cyc_q + 4'h1;
    wire [7:0] wbeat = wd_q[cyc_nx[2]][{cyc_nx[1:0], 3'b000} +: 8];
    wire full_q = cur_q[BL_MSB:BL_LSB] == BL_FULL && !(wrop_q && cur_q[WBM_BIT]);

    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = psel && penable && (!mapped || bad_go);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
            mode_q <= MODE_RST;
            col_q <= '0;
            wd_q[0] <= 32'h00000000;
            wd_q[1] <= 32'h00000000;
        end else begin
            if (setup) begin
                prdata_q <= rmux;
            end
            if (apb_wr && sel_mode) begin
                mode_q <= pwdata[MODE_W-1:0];
            end
            if (apb_wr && sel_col) begin
                col_q <= pwdata[COL_W-1:0];
            end
            if (apb_wr && sel_wd0) begin
                wd_q[0] <= pwdata;
            end
            if (apb_wr && sel_wd1) begin
                wd_q[1] <= pwdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            cur_q <= MODE_RST;
            cmd_q <= CMD_NOP;
            addr_q <= 12'h000;
            dqo_q <= 8'h00;
            dqoe_q <= 1'b0;
            wrop_q <= 1'b0;
            cyc_q <= 4'h0;
            rcnt_q <= 4'h0;
            nb_q <= 4'h0;
            gap_q <= 4'h0;
            rd_q[0] <= 32'h00000000;
            rd_q[1] <= 32'h00000000;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    cmd_q <= CMD_NOP;
                    if (go && pwdata[1:0] == OP_LOAD) begin
                        cmd_q <= CMD_LMR;
                        addr_q <= new_mode;
                        cur_q <= new_mode;
                        gap_q <= MRD_CYC;
                        state_q <= ST_WAIT;
                    end else if (go) begin
                        wrop_q <= pwdata[1:0] == OP_WRITE;
                        cmd_q <= (pwdata[1:0] == OP_WRITE) ? CMD_WRITE : CMD_READ;
                        addr_q <= 12'(col_q);
                        nb_q <= beats(cur_q, pwdata[1:0] == OP_WRITE);
                        dqo_q <= wd_q[0][7:0];
                        dqoe_q <= pwdata[1:0] == OP_WRITE;
                        cyc_q <= 4'h0;
                        rcnt_q <= 4'h0;
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    cyc_q <= cyc_nx;
                    cmd_q <= (full_q && cyc_nx == FULL_PAGE_BEATS) ? CMD_TERM : CMD_NOP;
                    if (wrop_q) begin
                        dqo_q <= wbeat;
                        if (cyc_nx == nb_q) begin
                            dqoe_q <= 1'b0;
                            gap_q <= TURN_CYC;
                            state_q <= ST_WAIT;
                        end
                    end else if (link.dq_dev_oe) begin
                        rd_q[rcnt_q[2]][{rcnt_q[1:0], 3'b000} +: 8] <= link.dq;
                        rcnt_q <= rcnt_q + 4'h1;
                        if (rcnt_q + 4'h1 == nb_q) begin
                            gap_q <= TURN_CYC;
                            state_q <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    cmd_q <= CMD_NOP;
                    if (gap_q == 4'h0) begin
                        state_q <= ST_IDLE;
                    end else begin
                        gap_q <= gap_q - 4'h1;
                    end
                end
            endcase
        end
    end

    assign link.cs_n = cmd_q[3];
    assign link.ras_n = cmd_q[2];
    assign link.cas_n = cmd_q[1];
    assign link.we_n = cmd_q[0];
    assign link.addr = addr_q;
    assign link.dq_ctl_o = dqo_q;
    assign link.dq_ctl_oe = dqoe_q;
endmodule // sbol_ctrl

// ==== rtl/sbol_device.sv ====
`timescale 1ns/100ps
module sbol_device
import sbol_pkg::*;
#(
    parameter int COL_W = sbol_pkg::COL_W_DEF,
    parameter int DQ_W = sbol_pkg::DQ_W_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    sbol_if.dev link,
    output logic [COL_W-1:0] arr_col,
    output logic arr_rd_en,
    output logic arr_wr_en,
    output logic [DQ_W-1:0] arr_wdata,
    input wire logic [DQ_W-1:0] arr_rdata,
    output logic burst_active,
    output logic [sbol_pkg::MODE_W-1:0] mode_word
);
    import sbol_pkg::*;

    if (COL_W < 3 || COL_W > 10) begin : g_col_chk
        $error("sbol_device: COL_W must lie in 3..10");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Functions
    function automatic logic [COL_W-1:0] len_mask(input logic [2:0] code);
        logic [COL_W-1:0] m;
        m = '0;
        unique case (code)
            BL_2: m = COL_W'(1);
            BL_4: m = COL_W'(3);
            BL_8: m = COL_W'(7);
            BL_FULL: m = '1;
            default: m = '0;
        endcase
        return m;
    endfunction

    function automatic logic [COL_W-1:0] burst_col(
        input logic [COL_W-1:0] start,
        input logic [COL_W-1:0] cnt,
        input logic [COL_W-1:0] mask,
        input logic ilv
    );
        logic [COL_W-1:0] off;
        off = ilv ? ((start ^ cnt) & mask) : ((start + cnt) & mask);
        return (start & ~mask) | off;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Command decode
    logic [MODE_W-1:0] mode_q;
    logic act_q;
    logic wr_q;
    logic ilv_q;
    logic l3_q;
    logic lok_q;
    logic [COL_W-1:0] mask_q;
    logic [COL_W-1:0] start_q;
    logic [COL_W-1:0] cnt_q;
    logic [COL_W-1:0] col_q;
    logic [DQ_W-1:0] wdata_q;
    logic [DQ_W-1:0] s1_q;
    logic s1v_q;
    logic [DQ_W-1:0] dq_q;
    logic oe_q;

    wire [3:0] cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
    wire is_lmr = cmd == CMD_LMR;
    wire is_rd = cmd == CMD_READ;
    wire is_wr = cmd == CMD_WRITE;
    wire is_term = cmd == CMD_TERM;
    wire op_normal = mode_q[OPM_MSB:OPM_LSB] == OPM_NORMAL;
    wire [2:0] bl_code = mode_q[BL_MSB:BL_LSB];
    wire [2:0] lat_code = mode_q[LAT_MSB:LAT_LSB];
    wire lat3 = lat_code == LAT_3;
    wire lat_ok = (lat_code == LAT_2) || lat3;
    wire start_burst = (is_rd || is_wr) && op_normal;
    wire single = is_wr && mode_q[WBM_BIT];
    wire full_d = !single && (bl_code == BL_FULL);
    // Length governs reads, and writes unless single
    wire [COL_W-1:0] mask_d = single ? '0 : len_mask(bl_code);
    // Interleave not offered for full page
    wire ilv_d = mode_q[BT_BIT] && !full_d;
    wire [COL_W-1:0] col_in = link.addr[COL_W-1:0];
    wire [COL_W-1:0] cnt_nx = cnt_q + 1'b1;
    wire last = cnt_q == mask_q;
    wire rd_fire = act_q && !wr_q && lok_q;

    ////////////////////////////////////////////////////////////////////////////
    // Mode word and column sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= MODE_RST;
            act_q <= 1'b0;
            wr_q <= 1'b0;
            ilv_q <= 1'b0;
            l3_q <= 1'b0;
            lok_q <= 1'b0;
            mask_q <= '0;
            start_q <= '0;
            cnt_q <= '0;
            col_q <= '0;
        end else begin
            if (is_lmr) begin
                mode_q <= link.addr;
            end
            if (start_burst) begin
                act_q <= 1'b1;
                wr_q <= is_wr;
                ilv_q <= ilv_d;
                l3_q <= lat3;
                lok_q <= lat_ok;
                mask_q <= mask_d;
                start_q <= col_in;
                cnt_q <= '0;
                col_q <= col_in;
            end else if (is_term || (act_q && last)) begin
                act_q <= 1'b0;
            end else if (act_q) begin
                cnt_q <= cnt_nx;
                col_q <= burst_col(start_q, cnt_nx, mask_q, ilv_q);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdata_q <= '0;
            s1_q <= '0;
            s1v_q <= 1'b0;
            dq_q <= '0;
            oe_q <= 1'b0;
        end else begin
            wdata_q <= link.dq;
            s1_q <= arr_rdata;
            s1v_q <= rd_fire;
            // Output stage loads at edge n+m-1
            dq_q <= l3_q ? s1_q : arr_rdata;
            oe_q <= l3_q ? s1v_q : rd_fire;
        end
    end

    assign arr_col = col_q;
    assign arr_rd_en = rd_fire;
    assign arr_wr_en = act_q && wr_q;
    assign arr_wdata = wdata_q;
    assign burst_active = act_q;
    assign mode_word = mode_q;
    assign link.dq_dev_o = dq_q;
    assign link.dq_dev_oe = oe_q;
endmodule // sbol_device

// ==== rtl/sbol_if.sv ====
`timescale 1ns/100ps
interface sbol_if #(parameter int DQ_W = 8) (input wire logic pclk);
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [11:0] addr;
    logic [DQ_W-1:0] dq_ctl_o;
    logic dq_ctl_oe;
    logic [DQ_W-1:0] dq_dev_o;
    logic dq_dev_oe;
    logic [DQ_W-1:0] dq;
    // Bus level resolved from the two enables
    assign dq = dq_dev_oe ? dq_dev_o : (dq_ctl_oe ? dq_ctl_o : '0);
    modport dev (input pclk, cs_n, ras_n, cas_n, we_n, addr, dq, dq_ctl_oe,
        output dq_dev_o, dq_dev_oe);
    modport ctl (input pclk, dq, dq_dev_oe,
        output cs_n, ras_n, cas_n, we_n, addr, dq_ctl_o, dq_ctl_oe);
endinterface

// ==== rtl/sbol_pkg.sv ====
package sbol_pkg;
    localparam int MODE_W = 12;
    localparam int ADDR_W = 12;
    localparam int DQ_W_DEF = 8;
    localparam int COL_W_DEF = 10;
    // Mode word field positions
    localparam int BL_LSB = 0;
    localparam int BL_MSB = 2;
    localparam int BT_BIT = 3;
    localparam int LAT_LSB = 4;
    localparam int LAT_MSB = 6;
    localparam int OPM_LSB = 7;
    localparam int OPM_MSB = 8;
    localparam int WBM_BIT = 9;
    localparam int RSV_LSB = 10;
    localparam int RSV_MSB = 11;
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [2:0] LAT_2 = 3'h2;
    localparam logic [2:0] LAT_3 = 3'h3;
    localparam logic [1:0] OPM_NORMAL = 2'h0;
    localparam logic [MODE_W-1:0] MODE_RST = 12'h000;
    // Command pins {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_TERM = 4'h6;
    localparam logic [3:0] CMD_LMR = 4'h0;
    // Controller timing
    localparam logic [3:0] FULL_PAGE_BEATS = 4'h8;
    localparam logic [3:0] MRD_CYC = 4'h2;
    localparam logic [3:0] TURN_CYC = 4'h1;
    // Controller register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_MODE = 8'h04;
    localparam logic [7:0] REG_COL = 8'h08;
    localparam logic [7:0] REG_WDAT0 = 8'h0C;
    localparam logic [7:0] REG_WDAT1 = 8'h10;
    localparam logic [7:0] REG_RDAT0 = 8'h14;
    localparam logic [7:0] REG_RDAT1 = 8'h18;
    localparam logic [7:0] REG_STAT = 8'h1C;
    localparam logic [1:0] OP_LOAD = 2'h0;
    localparam logic [1:0] OP_READ = 2'h1;
    localparam logic [1:0] OP_WRITE = 2'h2;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN = 3'b010,
        ST_WAIT = 3'b100
    } sbol_ctl_state_t;
endpackage

// ==== sim/sbol_properties.sv ====
`timescale 1ns/100ps
module sbol_properties
import sbol_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [11:0] addr,
    input wire logic dq_ctl_oe,
    input wire logic dq_dev_oe
);
    logic [MODE_W-1:0] mode_q;
    wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
    wire is_rd = (cmd == CMD_READ);
    wire is_wr = (cmd == CMD_WRITE);
    wire is_lmr = (cmd == CMD_LMR);
    wire [2:0] bl = mode_q[BL_MSB:BL_LSB];
    wire [2:0] lat = mode_q[LAT_MSB:LAT_LSB];
    wire norm = (mode_q[OPM_MSB:OPM_LSB] == OPM_NORMAL);
    wire wbm = mode_q[WBM_BIT];
    // Shadow of the mode word seen on the wire
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= MODE_RST;
        end else if (is_lmr) begin
            mode_q <= addr;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_lat2;
        !dq_dev_oe ##1 dq_dev_oe;
    endsequence
    sequence s_lat3;
        !dq_dev_oe [*2] ##1 dq_dev_oe;
    endsequence
    rd_lat2_a: assert property (is_rd && norm && lat == LAT_2 |=> s_lat2)
        else $error("read data not on time for latency two");
    rd_lat3_a: assert property (is_rd && norm && lat == LAT_3 |=> s_lat3)
        else $error("read data not on time for latency three");
    rd_len2_a: assert property ($rose(dq_dev_oe) && bl == BL_2 |-> dq_dev_oe [*2] ##1 !dq_dev_oe)
        else $error("read burst of two has wrong beat count");
    rd_len4_a: assert property ($rose(dq_dev_oe) && bl == BL_4 |-> dq_dev_oe [*4] ##1 !dq_dev_oe)
        else $error("read burst of four has wrong beat count");
    rd_len8_a: assert property ($rose(dq_dev_oe) && bl == BL_8 |-> dq_dev_oe [*8] ##1 !dq_dev_oe)
        else $error("read burst of eight has wrong beat count");
    wr_burst4_a: assert property (is_wr && !wbm && bl == BL_4 |-> dq_ctl_oe [*4] ##1 !dq_ctl_oe)
        else $error("write burst of four has wrong beat count");
    wr_single_a: assert property (is_wr && wbm |-> dq_ctl_oe ##1 !dq_ctl_oe)
        else $error("single write drove more than one beat");
    drive_clash_a: assert property (!(dq_dev_oe && dq_ctl_oe))
        else $error("both ends drive the data bus");
    mode_gap_a: assert property (is_lmr |=> (cmd == CMD_NOP) [*2])
        else $error("command too soon after mode load");
    mode_legal_a: assert property (is_lmr |-> addr[OPM_MSB:OPM_LSB] == OPM_NORMAL
        && addr[RSV_MSB:RSV_LSB] == 2'h0
        && (addr[LAT_MSB:LAT_LSB] == LAT_2 || addr[LAT_MSB:LAT_LSB] == LAT_3))
        else $error("illegal mode word loaded");
    full_seq_a: assert property (is_lmr && addr[BL_MSB:BL_LSB] == BL_FULL |-> !addr[BT_BIT])
        else $error("full page loaded with interleaved order");
endmodule // sbol_properties

// ==== sim/test_sdram_burst_order_and_latency.sv ====
`timescale 1ns/100ps
module test_sdram_burst_order_and_latency;
    import sbol_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [9:0] arr_col;
    logic arr_wr_en;
    logic arr_rd_en;
    logic burst_active;
    logic [11:0] mode_word;
    logic [7:0] arr_wdata;
    logic [7:0] arr_rdata;
    logic [7:0] mem [0:1023];
    logic [7:0] ref_m [0:1023];
    int failures = 0;
    int n_checks = 0;
    always #2 pclk = ~pclk;
    sbol_if #(.DQ_W(8)) link (.pclk(pclk));
    sbol_device sbol_device_inst (.pclk, .presetn, .link(link), .arr_col, .arr_rd_en,
        .arr_wr_en, .arr_wdata, .arr_rdata, .burst_active, .mode_word);
    sbol_ctrl #(.MIN_LAT(2)) sbol_ctrl_inst (.pclk, .presetn, .paddr, .psel, .penable,
        .pwrite, .pwdata, .pready, .prdata, .pslverr, .link(link));
    sbol_properties sbol_properties_inst (.pclk, .presetn, .cs_n(link.cs_n),
        .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .addr(link.addr),
        .dq_ctl_oe(link.dq_ctl_oe), .dq_dev_oe(link.dq_dev_oe));
    // Array model
    // Array answers only while the device asks for a read
    assign arr_rdata = arr_rd_en ? mem[arr_col] : 8'h00;
    always @(posedge pclk) if (arr_wr_en) mem[arr_col] <= arr_wdata;
    ////////////////////////////////////////////////////////////////
    function automatic logic [7:0] pat(input int c);
        return c[7:0] ^ {6'h2A, c[9:8]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
    endtask
    task automatic run(input logic [1:0] op);
        logic [31:0] r;
        logic e;
        wr(REG_CTRL, {30'h0, op});
        r = 32'h1;
        while (r[0] !== 1'b0) apb(REG_STAT, 1'b0, 32'h0, r, e);
    endtask
    task automatic load(input logic [11:0] m, input logic [11:0] m_exp);
        logic [31:0] r;
        logic e;
        wr(REG_MODE, {20'h0, m});
        run(OP_LOAD);
        apb(REG_STAT, 1'b0, 32'h0, r, e);
        check({20'h0, r[27:16]}, {20'h0, m_exp});
        check({20'h0, mode_word}, {20'h0, m_exp});
    endtask
    task automatic chk_rd(input logic [9:0] col, input int n, input logic [9:0] mask,
        input logic ilv);
        logic [31:0] r0;
        logic [31:0] r1;
        logic [31:0] s;
        logic e;
        logic [63:0] got;
        logic [9:0] c;
        wr(REG_COL, {22'h0, col});
        run(OP_READ);
        apb(REG_RDAT0, 1'b0, 32'h0, r0, e);
        apb(REG_RDAT1, 1'b0, 32'h0, r1, e);
        apb(REG_STAT, 1'b0, 32'h0, s, e);
        got = {r1, r0};
        check({28'h0, s[11:8]}, n[31:0]);
        check({31'h0, burst_active}, 32'h0);
        for (int i = 0; i < n; i++) begin
            c = ilv ? ((col & ~mask) | ((col ^ i[9:0]) & mask))
                    : ((col & ~mask) | ((col + i[9:0]) & mask));
            check({24'h0, got[8*i +: 8]}, {24'h0, ref_m[c]});
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        apb(REG_STAT, 1'b0, 32'h0, r, e);
        check(r, 32'h0);
        apb(8'h20, 1'b0, 32'h0, r, e);
        check({31'h0, e}, 32'h1);
        check(r, 32'h0);
        apb(REG_CTRL, 1'b1, 32'h3, r, e);
        check({31'h0, e}, 32'h1);
    endtask
    task automatic t_seq4;
        load(12'hDA2, 12'h022);
        chk_rd(10'h00D, 4, 10'h003, 1'b0);
    endtask
    task automatic t_ilv8;
        load(12'h03B, 12'h03B);
        chk_rd(10'h015, 8, 10'h007, 1'b1);
    endtask
    task automatic t_bl2;
        load(12'h031, 12'h031);
        chk_rd(10'h3FF, 2, 10'h001, 1'b0);
    endtask
    task automatic t_full;
        load(12'h02F, 12'h027);
        chk_rd(10'h3FD, 8, 10'h3FF, 1'b0);
    endtask
    task automatic t_bl1;
        load(12'h050, 12'h030);
        chk_rd(10'h123, 1, 10'h000, 1'b0);
    endtask
    task automatic t_write;
        load(12'h022, 12'h022);
        wr(REG_WDAT0, 32'hD4C3B2A1);
        wr(REG_COL, 32'h021);
        run(OP_WRITE);
        ref_m[10'h021] = 8'hA1;
        ref_m[10'h022] = 8'hB2;
        ref_m[10'h023] = 8'hC3;
        ref_m[10'h020] = 8'hD4;
        chk_rd(10'h020, 4, 10'h003, 1'b0);
        load(12'h222, 12'h222);
        wr(REG_WDAT0, 32'h44332211);
        wr(REG_COL, 32'h031);
        run(OP_WRITE);
        ref_m[10'h031] = 8'h11;
        chk_rd(10'h030, 4, 10'h003, 1'b0);
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = pat(i);
            ref_m[i] = pat(i);
        end
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_seq4;
        t_ilv8;
        t_bl2;
        t_full;
        t_bl1;
        t_write;
        tally_and_finish;
    end
    // Tests need a few hundred cycles; this is over a hundred times that
    initial begin
        #200000;
        failures++;
        tally_and_finish;
    end
endmodule // test_sdram_burst_order_and_latency
